// ### src/pcg_clk_divider.sv
// ratio divider producing a one-cycle clock tick
`timescale 1ns/1ps
`default_nettype none
module pcg_clk_divider
    import pcg_pkg::*;
#(
    parameter logic [2:0] RESET_SEL = 3'h1
)
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic [2:0] i_sel,
    output logic            o_tick
);

    typedef struct packed {
        logic [3:0] cnt;
        logic       tick;
    } pcg_div_state_t;

    pcg_div_state_t st_reg;
    pcg_div_state_t st_next;

    always_comb
    begin
        st_next = st_reg;
        // new ratio only taken at the period boundary, never mid-period
        if (st_reg.cnt == 4'h0)
        begin
            st_next.cnt  = pcg_div_limit(i_sel);
            st_next.tick = 1'b1;
        end
        else
        begin
            st_next.cnt  = st_reg.cnt - 4'h1;
            st_next.tick = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_reg <= '{cnt: 4'h0, tick: 1'b0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign o_tick = st_reg.tick;

endmodule // pcg_clk_divider
`default_nettype wire

// ### src/pcg_clock_ctrl.sv
// peripheral clock gating and prescaler registers on wishbone
// Functional notes
// - bit 8 gates capture unit 1, bit 9 capture unit 2; 1 runs.
// - gate one bits 7..3 gate pwm units 8..4.
// - gate one bits 2..0 gate pwm units 3..1.
// - all gate one enables are zero after reset.
// - pwm time-base runs only with unit enable and sync bit set.
// - sync low stops time-bases; setting it starts them aligned.
// - gate two bits 7..0 enable pwm units 16..9; 15:8 reserved.
// - gate two enables reset to zero and are software clearable.
// - fast divider field 2..0 divides by twice code, 0 undivided.
// - codes 000..111 give ratios 1,2,4,6,8,10,12,14.
// - fast divider field resets to 001, half system clock.
// - gating and divider writes only land while protection lifted.
// - slow divider same encoding, resets to 010, divide by four.
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pcg_clock_ctrl
    import pcg_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    output logic      [1:0]  o_capture_clk_en,
    output logic      [15:0] o_pwm_clk_en,
    output logic      [15:0] o_pwm_timebase_clk_en,
    output logic             o_fast_periph_clock_tick,
    output logic             o_slow_periph_clock_tick
);

    typedef struct packed {
        logic        first;
        logic        ack;
        logic [31:0] rdata;
        logic        wr_open;
        logic        sync;
        logic [15:0] gate_one;
        logic [7:0]  gate_two;
        logic [2:0]  fast_sel;
        logic [2:0]  slow_sel;
        logic [1:0]  cap_en;
        logic [15:0] pwm_en;
        logic [15:0] tb_en;
    } pcg_state_t;

    pcg_state_t st_reg;
    pcg_state_t st_next;

    logic       wr_commit;
    logic       prot_commit;
    logic [15:0] old_word;

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wdat,
                                            input logic [3:0]  sel,
                                            input logic [15:0] mask);
        logic [15:0] v;
        v = old;
        if (sel[0])
        begin
            v[7:0] = wdat[7:0];
        end
        if (sel[1])
        begin
            v[15:8] = wdat[15:8];
        end
        return v & mask;
    endfunction

    // write lands on the edge where the master sees ack
    assign wr_commit   = i_wb_cyc && i_wb_stb && i_wb_we && st_reg.ack;
    assign prot_commit = wr_commit && st_reg.wr_open;

    always_comb
    begin
        st_next       = st_reg;
        st_next.first = 1'b0;
        st_next.ack   = i_wb_cyc && i_wb_stb && !st_reg.ack;
        old_word      = 16'h0000;
        case (i_wb_adr)
            PCG_OFS_GATE_ZERO: old_word = 16'(st_reg.sync) << PCG_SYNC_BIT;
            PCG_OFS_GATE_ONE:  old_word = st_reg.gate_one;
            PCG_OFS_GATE_TWO:  old_word = {8'h00, st_reg.gate_two};
            PCG_OFS_FAST_DIV:  old_word = {13'h0000, st_reg.fast_sel};
            PCG_OFS_SLOW_DIV:  old_word = {13'h0000, st_reg.slow_sel};
            PCG_OFS_WR_GATE:   old_word = {15'h0000, st_reg.wr_open};
            default:           old_word = 16'h0000;
        endcase
        // unmapped addresses are acked and read zero
        st_next.rdata = {16'h0000, old_word};
        if (wr_commit && i_wb_adr == PCG_OFS_WR_GATE && i_wb_sel[0])
        begin
            st_next.wr_open = i_wb_dat[PCG_WR_GATE_BIT];
        end
        if (prot_commit)
        begin
            case (i_wb_adr)
                PCG_OFS_GATE_ZERO:
                begin
                    if (i_wb_sel[0])
                    begin
                        st_next.sync = i_wb_dat[PCG_SYNC_BIT];
                    end
                end
                PCG_OFS_GATE_ONE:
                begin
                    st_next.gate_one = merge16(st_reg.gate_one, i_wb_dat,
                                               i_wb_sel, PCG_GATE_ONE_MASK);
                end
                PCG_OFS_GATE_TWO:
                begin
                    st_next.gate_two = 8'(merge16({8'h00, st_reg.gate_two},
                                       i_wb_dat, i_wb_sel,
                                       PCG_GATE_TWO_MASK));
                end
                PCG_OFS_FAST_DIV:
                begin
                    st_next.fast_sel = 3'(merge16({13'h0000,
                                       st_reg.fast_sel}, i_wb_dat,
                                       i_wb_sel, PCG_DIV_MASK));
                end
                PCG_OFS_SLOW_DIV:
                begin
                    st_next.slow_sel = 3'(merge16({13'h0000,
                                       st_reg.slow_sel}, i_wb_dat,
                                       i_wb_sel, PCG_DIV_MASK));
                end
                default:
                begin
                    st_next.sync = st_reg.sync;
                end
            endcase
        end
        // enables are registered levels, so a gate change never chops
        // a clock pulse downstream
        st_next.cap_en = {st_reg.gate_one[PCG_CAP2_BIT],
                          st_reg.gate_one[PCG_CAP1_BIT]};
        st_next.pwm_en = {st_reg.gate_two,
                          st_reg.gate_one[7:0]};
        // one shared sync flop starts every time-base on the same edge
        st_next.tb_en  = st_next.pwm_en & {16{st_reg.sync}};
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_reg          <= '0;
            st_reg.first    <= 1'b1;
            st_reg.fast_sel <= PCG_FAST_DIV_RST;
            st_reg.slow_sel <= PCG_SLOW_DIV_RST;
            st_reg.gate_one <= PCG_GATE_RST;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    pcg_clk_divider #(
        .RESET_SEL (PCG_FAST_DIV_RST)
    ) u_fast_div (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_sel      (st_reg.fast_sel),
        .o_tick     (o_fast_periph_clock_tick)
    );

    pcg_clk_divider #(
        .RESET_SEL (PCG_SLOW_DIV_RST)
    ) u_slow_div (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_sel      (st_reg.slow_sel),
        .o_tick     (o_slow_periph_clock_tick)
    );

    assign o_wb_dat              = st_reg.rdata;
    assign o_wb_ack              = st_reg.ack;
    assign o_capture_clk_en      = st_reg.cap_en;
    assign o_pwm_clk_en          = st_reg.pwm_en;
    assign o_pwm_timebase_clk_en = st_reg.tb_en;

    logic gate_one_wr;
    assign gate_one_wr = prot_commit && i_wb_adr == PCG_OFS_GATE_ONE
                         && i_wb_sel[1:0] == 2'b11;

    property p_cap_gate;
        @(posedge i_core_clk) disable iff (i_rst)
        gate_one_wr |=> ##1 o_capture_clk_en == $past(i_wb_dat[9:8], 2);
    endproperty
    a_cap_gate: assert property (p_cap_gate)
        else $error("capture enable does not follow write");

    property p_pwm_hi;
        @(posedge i_core_clk) disable iff (i_rst)
        gate_one_wr |=> ##1 o_pwm_clk_en[7:3] == $past(i_wb_dat[7:3], 2);
    endproperty
    a_pwm_hi: assert property (p_pwm_hi)
        else $error("pwm 4..8 enable does not follow write");

    property p_pwm_lo;
        @(posedge i_core_clk) disable iff (i_rst)
        gate_one_wr |=> ##1 o_pwm_clk_en[2:0] == $past(i_wb_dat[2:0], 2);
    endproperty
    a_pwm_lo: assert property (p_pwm_lo)
        else $error("pwm 1..3 enable does not follow write");

    property p_rst_zero;
        @(posedge i_core_clk) disable iff (i_rst)
        st_reg.first |-> o_pwm_clk_en == 16'h0000
            && o_capture_clk_en == 2'h0 && st_reg.fast_sel == 3'h1;
    endproperty
    a_rst_zero: assert property (p_rst_zero)
        else $error("enables or divider wrong after reset");

    property p_tb_and;
        @(posedge i_core_clk) disable iff (i_rst)
        !st_reg.first |=> o_pwm_timebase_clk_en ==
            ({$past(st_reg.gate_two), $past(st_reg.gate_one[7:0])}
             & {16{$past(st_reg.sync)}});
    endproperty
    a_tb_and: assert property (p_tb_and)
        else $error("time-base enable not unit enable and sync");

    property p_sync_off;
        @(posedge i_core_clk) disable iff (i_rst)
        !st_reg.sync [*2] |-> o_pwm_timebase_clk_en == 16'h0000;
    endproperty
    a_sync_off: assert property (p_sync_off)
        else $error("time-base running while sync low");

    property p_gate_two;
        @(posedge i_core_clk) disable iff (i_rst)
        (prot_commit && i_wb_adr == PCG_OFS_GATE_TWO && i_wb_sel[0])
            |=> ##1 o_pwm_clk_en[15:8] == $past(i_wb_dat[7:0], 2);
    endproperty
    a_gate_two: assert property (p_gate_two)
        else $error("pwm 9..16 enable does not follow write");

    property p_locked;
        @(posedge i_core_clk) disable iff (i_rst)
        (wr_commit && !st_reg.wr_open) |=> $stable(st_reg.gate_one)
            && $stable(st_reg.gate_two) && $stable(st_reg.fast_sel)
            && $stable(st_reg.slow_sel) && $stable(st_reg.sync);
    endproperty
    a_locked: assert property (p_locked)
        else $error("protected register changed while locked");

    // the divider reloads from the code seen one cycle before the tick
    property p_fast_half;
        @(posedge i_core_clk) disable iff (i_rst)
        (o_fast_periph_clock_tick && $past(st_reg.fast_sel) == 3'h1)
            |=> !o_fast_periph_clock_tick ##1 o_fast_periph_clock_tick;
    endproperty
    a_fast_half: assert property (p_fast_half)
        else $error("fast divide by two period wrong");

    property p_slow_quarter;
        @(posedge i_core_clk) disable iff (i_rst)
        (o_slow_periph_clock_tick && $past(st_reg.slow_sel) == 3'h2)
            |=> !o_slow_periph_clock_tick [*3] ##1 o_slow_periph_clock_tick;
    endproperty
    a_slow_quarter: assert property (p_slow_quarter)
        else $error("slow divide by four period wrong");

    property p_no_runt;
        @(posedge i_core_clk) disable iff (i_rst)
        (o_fast_periph_clock_tick && $past(st_reg.fast_sel) != 3'h0)
            |=> !o_fast_periph_clock_tick;
    endproperty
    a_no_runt: assert property (p_no_runt)
        else $error("fast tick period cut short");

    property p_fast_six;
        @(posedge i_core_clk) disable iff (i_rst)
        (o_fast_periph_clock_tick && $past(st_reg.fast_sel) == 3'h3)
            |=> !o_fast_periph_clock_tick [*5] ##1 o_fast_periph_clock_tick;
    endproperty
    a_fast_six: assert property (p_fast_six)
        else $error("fast divide by six period wrong");

    property p_slow_undiv;
        @(posedge i_core_clk) disable iff (i_rst)
        (o_slow_periph_clock_tick && $past(st_reg.slow_sel) == 3'h0)
            |=> o_slow_periph_clock_tick;
    endproperty
    a_slow_undiv: assert property (p_slow_undiv)
        else $error("slow undivided clock missed a cycle");

    property p_div_rsvd;
        @(posedge i_core_clk) disable iff (i_rst)
        (o_wb_ack && (i_wb_adr == PCG_OFS_FAST_DIV
                      || i_wb_adr == PCG_OFS_SLOW_DIV))
            |-> o_wb_dat[31:3] == 29'h0;
    endproperty
    a_div_rsvd: assert property (p_div_rsvd)
        else $error("divider reserved bits read nonzero");

    c_unlocked_write: cover property (@(posedge i_core_clk)
        disable iff (i_rst) prot_commit);
    c_locked_write: cover property (@(posedge i_core_clk)
        disable iff (i_rst) wr_commit && !st_reg.wr_open);
    c_tb_start: cover property (@(posedge i_core_clk)
        disable iff (i_rst) $rose(o_pwm_timebase_clk_en != 16'h0000));
    c_fast_undiv: cover property (@(posedge i_core_clk)
        disable iff (i_rst) st_reg.fast_sel == 3'h0
        && o_fast_periph_clock_tick);

endmodule // pcg_clock_ctrl
`default_nettype wire

// ### src/pcg_pkg.sv
// constants and helpers shared by the peripheral clock gating block
package pcg_pkg;

    // register byte offsets on the wishbone bus
    localparam logic [7:0] PCG_OFS_GATE_ZERO  = 8'h00;
    localparam logic [7:0] PCG_OFS_GATE_ONE   = 8'h04;
    localparam logic [7:0] PCG_OFS_GATE_TWO   = 8'h08;
    localparam logic [7:0] PCG_OFS_FAST_DIV   = 8'h0c;
    localparam logic [7:0] PCG_OFS_SLOW_DIV   = 8'h10;
    localparam logic [7:0] PCG_OFS_WR_GATE    = 8'h14;

    // field positions
    localparam int PCG_SYNC_BIT      = 2;
    localparam int PCG_WR_GATE_BIT   = 0;
    localparam int PCG_CAP1_BIT      = 8;
    localparam int PCG_CAP2_BIT      = 9;

    // writable bits; 13:12 of gate one and 15:8 of gate two read zero
    localparam logic [15:0] PCG_GATE_ONE_MASK = 16'hcfff;
    localparam logic [15:0] PCG_GATE_TWO_MASK = 16'h00ff;
    localparam logic [15:0] PCG_DIV_MASK      = 16'h0007;

    // values after reset
    localparam logic [15:0] PCG_GATE_RST      = 16'h0000;
    localparam logic [2:0]  PCG_FAST_DIV_RST  = 3'h1;
    localparam logic [2:0]  PCG_SLOW_DIV_RST  = 3'h2;

    // cycles between ticks minus one: code 0 gives every cycle,
    // otherwise 2*code cycles
    function automatic logic [3:0] pcg_div_limit(input logic [2:0] sel);
        logic [3:0] lim;
        lim = 4'h0;
        if (sel != 3'h0)
        begin
            lim = {sel, 1'b0} - 4'h1;
        end
        return lim;
    endfunction

endpackage

// ### testbench/tb_top.sv
// self-checking bench for the peripheral clock gating block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pcg_pkg::*;

    logic        i_core_clk;
    logic        i_rst;
    logic        i_wb_cyc;
    logic        i_wb_stb;
    logic        i_wb_we;
    logic [7:0]  i_wb_adr;
    logic [3:0]  i_wb_sel;
    logic [31:0] i_wb_dat;
    logic [31:0] o_wb_dat;
    logic        o_wb_ack;
    logic [1:0]  o_capture_clk_en;
    logic [15:0] o_pwm_clk_en;
    logic [15:0] o_pwm_timebase_clk_en;
    logic        o_fast_periph_clock_tick;
    logic        o_slow_periph_clock_tick;
    logic [31:0] per;
    int          error_cnt;
    int          comparisons;

    pcg_clock_ctrl pcg_clock_ctrl_inst (
        .i_core_clk              (i_core_clk),
        .i_rst                   (i_rst),
        .i_wb_cyc                (i_wb_cyc),
        .i_wb_stb                (i_wb_stb),
        .i_wb_we                 (i_wb_we),
        .i_wb_adr                (i_wb_adr),
        .i_wb_sel                (i_wb_sel),
        .i_wb_dat                (i_wb_dat),
        .o_wb_dat                (o_wb_dat),
        .o_wb_ack                (o_wb_ack),
        .o_capture_clk_en        (o_capture_clk_en),
        .o_pwm_clk_en            (o_pwm_clk_en),
        .o_pwm_timebase_clk_en   (o_pwm_timebase_clk_en),
        .o_fast_periph_clock_tick(o_fast_periph_clock_tick),
        .o_slow_periph_clock_tick(o_slow_periph_clock_tick)
    );

    initial
    begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // classic cycle: hold everything until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [7:0] adr,
                           input logic [31:0] wdat,
                           output logic [31:0] rdat);
        int n;
        n = 0;
        @(posedge i_core_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we  <= we;
        i_wb_adr <= adr;
        i_wb_dat <= wdat;
        i_wb_sel <= 4'hf;
        do
        begin
            @(posedge i_core_clk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 16);
        rdat = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        i_wb_we  <= 1'b0;
        if (n >= 16)
        begin
            error_cnt++;
            stop_test();
        end
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] r;
        wb_xfer(1'b1, adr, d, r);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] r;
        wb_xfer(1'b0, adr, 32'h0, r);
        check(r, exp);
    endtask

    // third interval is measured so a ratio change has settled
    task automatic tick_period(input logic slow, output logic [31:0] p);
        int n;
        n = 0;
        for (int k = 0; k < 3; k++)
        begin
            n = 0;
            do
            begin
                @(posedge i_core_clk);
                n++;
            end while ((slow ? o_slow_periph_clock_tick
                             : o_fast_periph_clock_tick) !== 1'b1 && n < 40);
        end
        p = 32'(n);
    endtask

    initial
    begin
        #(20000 * 20);
        error_cnt++;
        stop_test();
    end

    initial
    begin
        error_cnt = 0;
        comparisons = 0;
        i_rst = 1'b1;
        i_wb_cyc = 1'b0;
        i_wb_stb = 1'b0;
        i_wb_we = 1'b0;
        i_wb_adr = 8'h00;
        i_wb_sel = 4'h0;
        i_wb_dat = 32'h0;
        repeat (8) @(posedge i_core_clk);
        i_rst <= 1'b0;
        rd_chk(PCG_OFS_GATE_ONE, 32'h0);
        rd_chk(PCG_OFS_GATE_TWO, 32'h0);
        rd_chk(PCG_OFS_FAST_DIV, 32'h1);
        rd_chk(PCG_OFS_SLOW_DIV, 32'h2);
        check({30'h0, o_capture_clk_en}, 32'h0);
        check({16'h0, o_pwm_clk_en}, 32'h0);
        tick_period(1'b0, per);
        check(per, 32'h2);
        tick_period(1'b1, per);
        check(per, 32'h4);
        // protection still closed: writes are acked and dropped
        wr(PCG_OFS_GATE_ONE, 32'hffff);
        wr(PCG_OFS_FAST_DIV, 32'h0);
        rd_chk(PCG_OFS_GATE_ONE, 32'h0);
        rd_chk(PCG_OFS_FAST_DIV, 32'h1);
        wr(PCG_OFS_WR_GATE, 32'h1);
        wr(PCG_OFS_GATE_ONE, 32'hffff);
        rd_chk(PCG_OFS_GATE_ONE, 32'hcfff);
        check({30'h0, o_capture_clk_en}, 32'h3);
        check({16'h0, o_pwm_clk_en}, 32'h00ff);
        check({16'h0, o_pwm_timebase_clk_en}, 32'h0);
        wr(PCG_OFS_GATE_ZERO, 32'h4);
        rd_chk(PCG_OFS_GATE_ZERO, 32'h4);
        check({16'h0, o_pwm_timebase_clk_en}, 32'h00ff);
        wr(PCG_OFS_GATE_TWO, 32'hffff);
        rd_chk(PCG_OFS_GATE_TWO, 32'h00ff);
        check({16'h0, o_pwm_clk_en}, 32'hffff);
        check({16'h0, o_pwm_timebase_clk_en}, 32'hffff);
        wr(PCG_OFS_GATE_ZERO, 32'h0);
        wr(PCG_OFS_GATE_ONE, 32'h0205);
        rd_chk(PCG_OFS_GATE_ONE, 32'h0205);
        check({16'h0, o_pwm_timebase_clk_en}, 32'h0);
        check({30'h0, o_capture_clk_en}, 32'h2);
        wr(PCG_OFS_GATE_TWO, 32'h0);
        rd_chk(PCG_OFS_GATE_TWO, 32'h0);
        check({16'h0, o_pwm_clk_en}, 32'h0005);
        for (int c = 0; c < 8; c++)
        begin
            wr(PCG_OFS_FAST_DIV, 32'(c));
            wr(PCG_OFS_SLOW_DIV, 32'(7 - c));
            rd_chk(PCG_OFS_FAST_DIV, 32'(c));
            tick_period(1'b0, per);
            check(per, (c == 0) ? 32'h1 : 32'(2 * c));
            tick_period(1'b1, per);
            check(per, (c == 7) ? 32'h1 : 32'(14 - 2 * c));
        end
        wr(8'h20, 32'hffff);
        rd_chk(8'h20, 32'h0);
        wr(PCG_OFS_WR_GATE, 32'h0);
        wr(PCG_OFS_FAST_DIV, 32'h3);
        rd_chk(PCG_OFS_FAST_DIV, 32'h7);
        stop_test();
    end

endmodule // tb_top
`default_nettype wire
